/* File: common/ddcpc_cfg.svh */
// register map, field positions, reset values and patterns of the path control block
`ifndef DDCPC_CFG_SVH
`define DDCPC_CFG_SVH

// register indices as printed; byte address is four times the index
`define DDCPC_IDX_FCLK0       8'h20
`define DDCPC_IDX_FCLK1       8'h21
`define DDCPC_IDX_FCLK2       8'h22
`define DDCPC_IDX_PATH        8'h24
`define DDCPC_IDX_DECIM       8'h25
`define DDCPC_IDX_STATUS      8'h28

// digital_path_config fields
`define DDCPC_PATH_AVG_BIT    5
`define DDCPC_PATH_SEL_HI     4
`define DDCPC_PATH_SEL_LO     3
`define DDCPC_PATH_DIG_BIT    2
`define DDCPC_PATH_DEC_BIT    1
`define DDCPC_PATH_RESET      8'h00

// decimation_config fields
`define DDCPC_DEC_MUXEN_BIT   7
`define DDCPC_DEC_RATIO_HI    6
`define DDCPC_DEC_RATIO_LO    4
`define DDCPC_DEC_REAL_BIT    3
`define DDCPC_DEC_PHASE_BIT   0
`define DDCPC_DEC_RESET       8'h00
`define DDCPC_RATIO_MAX       3'h5

// frame clock pattern register 2 fields
`define DDCPC_FCLK2_SCR_BIT   6
`define DDCPC_FRAME_CLOCK_RESET      20'hFFC00

// automatic bypass patterns per output resolution
`define DDCPC_FRAME_CLOCK_BYP_18     20'hFF800
`define DDCPC_FRAME_CLOCK_BYP_16     20'hFF000
`define DDCPC_FRAME_CLOCK_BYP_14     20'hFE000

// ahb-lite transfer codes
`define DDCPC_HTRANS_NONSEQ   2'h2
`define DDCPC_HTRANS_SEQ      2'h3

`endif

/* File: common/ddcpc_pkg.sv */
// types shared by the path control block
package ddcpc_pkg;

  typedef logic signed [17:0] ddcpc_sample_t;

  // filter input selector codes
  typedef enum logic [1:0] {
    DDCPC_SEL_OWN  = 2'h0,
    DDCPC_SEL_A    = 2'h1,
    DDCPC_SEL_B    = 2'h2,
    DDCPC_SEL_AVG  = 2'h3
  } ddcpc_sel_t;

  // bus data phase, one-hot
  typedef enum logic [2:0] {
    DDCPC_PH_IDLE  = 3'h1,
    DDCPC_PH_WRITE = 3'h2,
    DDCPC_PH_READ  = 3'h4
  } ddcpc_phase_t;

endpackage

/* File: hdl/ddcpc_path_ctrl.sv */
// digital feature path control: registers, input routing, averaging and decimation pacing
//
// Summary of operation
// - averaging enabled gives (A+B)/2 instead of a single channel
// - selector 00 own, 01 A to both, 10 B to both, 11 average
// - digital path off skips decimation and scrambling; on uses feature block
// - decimator enable bit turns both channel filters on or off
// - selector only acts while mux enable is set
// - ratio 000 none, 001..101 divide by 2..32; others unused
// - real output bit gives low-pass decimation without complex mixing
// - mix phase bit inverts oscillator phase
// - 20-bit frame pattern over three registers, reset FFC00, auto in bypass
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "ddcpc_cfg.svh"

module ddcpc_path_ctrl (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // converter samples and oscillator phase
  input  wire ddcpc_pkg::ddcpc_sample_t sample_a,
  input  wire ddcpc_pkg::ddcpc_sample_t sample_b,
  input  wire logic [1:0]             bypass_resolution,
  input  wire logic [31:0]            nco_phase,
  // filter feed
  output ddcpc_pkg::ddcpc_sample_t    filter_a_in,
  output ddcpc_pkg::ddcpc_sample_t    filter_b_in,
  output logic                        filter_enable,
  output logic [2:0]                  decim_ratio,
  output logic                        decim_strobe,
  output logic                        real_mode,
  output logic                        complex_mix_enable,
  output logic [31:0]                 mixer_phase,
  // output path toward the serial link
  output ddcpc_pkg::ddcpc_sample_t    path_a_out,
  output ddcpc_pkg::ddcpc_sample_t    path_b_out,
  output logic                        path_valid,
  output logic                        scrambler_enable,
  output logic [19:0]                 frame_clock_pattern
);

  // stored register fields; reserved bits are not kept
  logic                       channel_average_enable;
  ddcpc_pkg::ddcpc_sel_t      filter_input_select;
  logic                       digital_path_enable;
  logic                       decimator_enable;
  logic                       filter_input_mux_enable;
  logic [2:0]                 ratio_field;
  logic                       real_out;
  logic                       mix_phase;
  logic [19:0]                frame_clock_field;
  logic                       scr_field;
  logic                       next_channel_average_enable;
  ddcpc_pkg::ddcpc_sel_t      next_filter_input_select;
  logic                       next_digital_path_enable;
  logic                       next_decimator_enable;
  logic                       next_filter_input_mux_enable;
  logic [2:0]                 next_ratio_field;
  logic                       next_real_out;
  logic                       next_mix_phase;
  logic [19:0]                next_frame_clock_field;
  logic                       next_scr_field;

  // bus phase tracking
  ddcpc_pkg::ddcpc_phase_t    phase;
  ddcpc_pkg::ddcpc_phase_t    next_phase;
  logic [7:0]                 addr_idx;
  logic [7:0]                 next_addr_idx;
  logic [31:0]                next_hrdata;
  logic                       addr_ok;
  logic                       take;
  logic [7:0]                 rd_byte;
  logic [7:0]                 status_byte;

  // datapath
  ddcpc_pkg::ddcpc_sel_t      eff_sel;
  logic signed [18:0]         pair_sum;
  ddcpc_pkg::ddcpc_sample_t   avg_sample;
  ddcpc_pkg::ddcpc_sample_t   next_filter_a_in;
  ddcpc_pkg::ddcpc_sample_t   next_filter_b_in;
  ddcpc_pkg::ddcpc_sample_t   next_path_a_out;
  ddcpc_pkg::ddcpc_sample_t   next_path_b_out;
  logic                       ratio_legal;
  logic                       decim_on;
  logic [4:0]                 div_count;
  logic [4:0]                 next_div_count;
  logic [4:0]                 div_limit;
  logic                       next_decim_strobe;
  logic                       next_path_valid;
  logic [19:0]                next_frame_clock_pattern;
  logic [31:0]                next_mixer_phase;

  // address decode: word aligned, upper bits zero, index = byte address / 4
  always_comb begin
    take    = hsel && hready && (htrans == `DDCPC_HTRANS_NONSEQ ||
                                 htrans == `DDCPC_HTRANS_SEQ);
    addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
  end

  // status: effective routing and filter state
  always_comb begin
    status_byte      = 8'h00;
    status_byte[0]   = filter_enable;
    status_byte[1]   = filter_input_mux_enable;
    status_byte[3:2] = eff_sel;
    status_byte[4]   = channel_average_enable && eff_sel == ddcpc_pkg::DDCPC_SEL_AVG;
    status_byte[5]   = ratio_legal;
    status_byte[6]   = decim_on;
  end

  // read mux; reserved bits read as zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (haddr[9:2])
      `DDCPC_IDX_FCLK0:  rd_byte = frame_clock_field[7:0];
      `DDCPC_IDX_FCLK1:  rd_byte = frame_clock_field[15:8];
      `DDCPC_IDX_FCLK2:  rd_byte = {1'b0, scr_field, 2'b00, frame_clock_field[19:16]};
      `DDCPC_IDX_PATH:   rd_byte = {2'b00, channel_average_enable, filter_input_select,
                                    digital_path_enable, decimator_enable, 1'b0};
      `DDCPC_IDX_DECIM:  rd_byte = {filter_input_mux_enable, ratio_field, real_out,
                                    2'b00, mix_phase};
      `DDCPC_IDX_STATUS: rd_byte = status_byte;
      default:           rd_byte = 8'h00;
    endcase
  end

  // bus next state: read data is prepared for the data phase
  always_comb begin
    next_phase    = ddcpc_pkg::DDCPC_PH_IDLE;
    next_addr_idx = addr_idx;
    next_hrdata   = hrdata;
    if (take && addr_ok) begin
      next_addr_idx = haddr[9:2];
      next_phase    = hwrite ? ddcpc_pkg::DDCPC_PH_WRITE : ddcpc_pkg::DDCPC_PH_READ;
    end
    if (take && !hwrite) begin
      next_hrdata = addr_ok ? {24'h0, rd_byte} : 32'h0;
    end
  end

  // register writes land in the data phase; reserved bits are dropped
  always_comb begin
    next_channel_average_enable  = channel_average_enable;
    next_filter_input_select     = filter_input_select;
    next_digital_path_enable     = digital_path_enable;
    next_decimator_enable        = decimator_enable;
    next_filter_input_mux_enable = filter_input_mux_enable;
    next_ratio_field             = ratio_field;
    next_real_out                = real_out;
    next_mix_phase               = mix_phase;
    next_frame_clock_field              = frame_clock_field;
    next_scr_field               = scr_field;
    if (phase == ddcpc_pkg::DDCPC_PH_WRITE) begin
      unique case (addr_idx)
        `DDCPC_IDX_FCLK0: next_frame_clock_field[7:0] = hwdata[7:0];
        `DDCPC_IDX_FCLK1: next_frame_clock_field[15:8] = hwdata[7:0];
        `DDCPC_IDX_FCLK2: begin
          next_frame_clock_field[19:16] = hwdata[3:0];
          next_scr_field         = hwdata[`DDCPC_FCLK2_SCR_BIT];
        end
        `DDCPC_IDX_PATH: begin
          next_channel_average_enable = hwdata[`DDCPC_PATH_AVG_BIT];
          next_filter_input_select    = ddcpc_pkg::ddcpc_sel_t'(
                                          hwdata[`DDCPC_PATH_SEL_HI:`DDCPC_PATH_SEL_LO]);
          next_digital_path_enable    = hwdata[`DDCPC_PATH_DIG_BIT];
          next_decimator_enable       = hwdata[`DDCPC_PATH_DEC_BIT];
        end
        `DDCPC_IDX_DECIM: begin
          next_filter_input_mux_enable = hwdata[`DDCPC_DEC_MUXEN_BIT];
          next_ratio_field             = hwdata[`DDCPC_DEC_RATIO_HI:`DDCPC_DEC_RATIO_LO];
          next_real_out                = hwdata[`DDCPC_DEC_REAL_BIT];
          next_mix_phase               = hwdata[`DDCPC_DEC_PHASE_BIT];
        end
        default: next_frame_clock_field = frame_clock_field;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase                   <= ddcpc_pkg::DDCPC_PH_IDLE;
      addr_idx                <= 8'h00;
      hrdata                  <= 32'h0;
      hreadyout               <= 1'b1;
      hresp                   <= 1'b0;
      channel_average_enable  <= 1'b0;
      filter_input_select     <= ddcpc_pkg::DDCPC_SEL_OWN;
      digital_path_enable     <= 1'b0;
      decimator_enable        <= 1'b0;
      filter_input_mux_enable <= 1'b0;
      ratio_field             <= 3'h0;
      real_out                <= 1'b0;
      mix_phase               <= 1'b0;
      frame_clock_field              <= `DDCPC_FRAME_CLOCK_RESET;
      scr_field               <= 1'b0;
    end else begin
      phase                   <= next_phase;
      addr_idx                <= next_addr_idx;
      hrdata                  <= next_hrdata;
      hreadyout               <= 1'b1;
      hresp                   <= 1'b0;
      channel_average_enable  <= next_channel_average_enable;
      filter_input_select     <= next_filter_input_select;
      digital_path_enable     <= next_digital_path_enable;
      decimator_enable        <= next_decimator_enable;
      filter_input_mux_enable <= next_filter_input_mux_enable;
      ratio_field             <= next_ratio_field;
      real_out                <= next_real_out;
      mix_phase               <= next_mix_phase;
      frame_clock_field              <= next_frame_clock_field;
      scr_field               <= next_scr_field;
    end
  end

  // input routing and averaging
  always_comb begin
    eff_sel    = filter_input_mux_enable ? filter_input_select
                                         : ddcpc_pkg::DDCPC_SEL_OWN;
    pair_sum   = 19'(sample_a) + 19'(sample_b);
    avg_sample = channel_average_enable ? pair_sum[18:1] : sample_a;
    next_filter_a_in = sample_a;
    next_filter_b_in = sample_b;
    unique case (eff_sel)
      ddcpc_pkg::DDCPC_SEL_OWN: begin
        next_filter_a_in = sample_a;
        next_filter_b_in = sample_b;
      end
      ddcpc_pkg::DDCPC_SEL_A: begin
        next_filter_a_in = sample_a;
        next_filter_b_in = sample_a;
      end
      ddcpc_pkg::DDCPC_SEL_B: begin
        next_filter_a_in = sample_b;
        next_filter_b_in = sample_b;
      end
      ddcpc_pkg::DDCPC_SEL_AVG: begin
        next_filter_a_in = avg_sample;
        next_filter_b_in = avg_sample;
      end
    endcase
  end

  // decimation pacing, output path, mixer phase and frame pattern
  always_comb begin
    ratio_legal       = ratio_field <= `DDCPC_RATIO_MAX;
    decim_on          = digital_path_enable && decimator_enable &&
                        ratio_legal && ratio_field != 3'h0;
    div_limit         = 5'((6'h1 << ratio_field) - 6'h1);
    next_div_count    = 5'h0;
    next_decim_strobe = 1'b0;
    if (decim_on) begin
      next_decim_strobe = div_count == div_limit;
      next_div_count    = (div_count == div_limit) ? 5'h0 : div_count + 5'h1;
    end
    if (digital_path_enable) begin
      next_path_a_out = next_filter_a_in;
      next_path_b_out = next_filter_b_in;
      next_path_valid = decim_on ? next_decim_strobe : 1'b1;
    end else begin
      next_path_a_out = sample_a;
      next_path_b_out = sample_b;
      next_path_valid = 1'b1;
    end
    next_mixer_phase = mix_phase ? 32'(-nco_phase) : nco_phase;
    next_frame_clock_pattern = frame_clock_field;
    if (!digital_path_enable) begin
      unique case (bypass_resolution)
        2'h1:    next_frame_clock_pattern = `DDCPC_FRAME_CLOCK_BYP_16;
        2'h2:    next_frame_clock_pattern = `DDCPC_FRAME_CLOCK_BYP_14;
        default: next_frame_clock_pattern = `DDCPC_FRAME_CLOCK_BYP_18;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      filter_a_in         <= 18'sh0;
      filter_b_in         <= 18'sh0;
      filter_enable       <= 1'b0;
      decim_ratio         <= 3'h0;
      decim_strobe        <= 1'b0;
      real_mode           <= 1'b0;
      complex_mix_enable  <= 1'b0;
      mixer_phase         <= 32'h0;
      path_a_out          <= 18'sh0;
      path_b_out          <= 18'sh0;
      path_valid          <= 1'b0;
      scrambler_enable    <= 1'b0;
      frame_clock_pattern <= `DDCPC_FRAME_CLOCK_RESET;
      div_count           <= 5'h0;
    end else begin
      filter_a_in         <= next_filter_a_in;
      filter_b_in         <= next_filter_b_in;
      filter_enable       <= digital_path_enable && decimator_enable;
      decim_ratio         <= decim_on ? ratio_field : 3'h0;
      decim_strobe        <= next_decim_strobe;
      real_mode           <= real_out;
      complex_mix_enable  <= digital_path_enable && decimator_enable && !real_out;
      mixer_phase         <= next_mixer_phase;
      path_a_out          <= next_path_a_out;
      path_b_out          <= next_path_b_out;
      path_valid          <= next_path_valid;
      scrambler_enable    <= scr_field && digital_path_enable;
      frame_clock_pattern <= next_frame_clock_pattern;
      div_count           <= next_div_count;
    end
  end

endmodule

/* File: tb/ddcpc_chk.sv */
// assertion checker bound to the path control block
`timescale 1ns/1ps
module ddcpc_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // bus answer
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // path control
  input wire logic [31:0] nco_phase,
  input wire logic        filter_enable,
  input wire logic [2:0]  decim_ratio,
  input wire logic        decim_strobe,
  input wire logic        real_mode,
  input wire logic        complex_mix_enable,
  input wire logic [31:0] mixer_phase,
  input wire logic        path_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_bus_okay: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0)
    else $error("bus answer wrong");
  a_ratio_legal: assert property (decim_ratio <= 3'h5)
    else $error("ratio out of range");
  a_filter_off: assert property (!filter_enable |-> decim_ratio == 3'h0 && !decim_strobe)
    else $error("decimating while filters off");
  a_strobe_valid: assert property (decim_strobe |-> path_valid)
    else $error("strobe without valid");
  a_full_rate: assert property (!$past(rst) && decim_ratio == 3'h0 |-> path_valid)
    else $error("full rate valid missing");
  a_strobe_gap: assert property (decim_strobe && decim_ratio == 3'h2 |=>
    (!decim_strobe || decim_ratio != 3'h2) [*3] ##1 (decim_strobe || decim_ratio != 3'h2))
    else $error("divide by four spacing wrong");
  a_mix_phase: assert property (!$past(rst) |-> mixer_phase == $past(nco_phase)
    || mixer_phase == -$past(nco_phase))
    else $error("mixer phase wrong");
  a_complex_mix: assert property (complex_mix_enable == (filter_enable && !real_mode))
    else $error("complex mixing state wrong");
  c_ratio_max: cover property (decim_strobe && decim_ratio == 3'h5);
  c_complex: cover property (complex_mix_enable);
  c_real: cover property (real_mode && filter_enable);
endmodule

bind ddcpc_path_ctrl ddcpc_chk ddcpc_chk_inst (
  .clk(clk), .rst(rst), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .nco_phase(nco_phase), .filter_enable(filter_enable), .decim_ratio(decim_ratio),
  .decim_strobe(decim_strobe), .real_mode(real_mode),
  .complex_mix_enable(complex_mix_enable), .mixer_phase(mixer_phase),
  .path_valid(path_valid)
);

/* File: tb/ddcpc_rx.sv */
// serial link receiver model counting delivered words
`timescale 1ns/1ps
module ddcpc_rx (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // link side
  input  wire logic        valid,
  output logic      [15:0] words
);
  logic [15:0] next_words;
  always_comb begin
    next_words = valid ? words + 16'h1 : words;
  end
  always_ff @(posedge clk) begin
    words <= rst ? 16'h0 : next_words;
  end
endmodule

/* File: tb/ddcpc_tb.sv */
// self-checking testbench of the path control block
`timescale 1ns/1ps
`include "ddcpc_cfg.svh"
module tb;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic                     hsel = 1'b1;
  logic [31:0]              haddr = 32'h0;
  logic [1:0]               htrans = 2'h0;
  logic                     hwrite = 1'b0;
  logic [31:0]              hwdata = 32'h0;
  logic [31:0]              nco_phase = 32'h0;
  logic [1:0]               bypass_resolution = 2'h0;
  ddcpc_pkg::ddcpc_sample_t sample_a = 18'h0;
  ddcpc_pkg::ddcpc_sample_t sample_b = 18'h0;
  logic [31:0]              hrdata, mixer_phase;
  logic                     hreadyout, hresp, filter_enable, decim_strobe, real_mode;
  logic                     complex_mix_enable, path_valid, scrambler_enable;
  ddcpc_pkg::ddcpc_sample_t filter_a_in, filter_b_in, path_a_out, path_b_out;
  logic [2:0]               decim_ratio;
  logic [19:0]              frame_clock_pattern;
  logic [15:0]              words, w0;
  integer                   seed = 32'hDD4A2852;
  int                       bad_count = 0;
  int                       check_count = 0;
  int                       mode, i, r;
  logic                     rdf = 1'b0;
  logic                     dwatch = 1'b0;
  logic                     w1 = 1'b0;
  logic [31:0]              rq [$];
  logic [36:0]              dq [$];
  logic [19:0]              fp [4] = '{`DDCPC_FRAME_CLOCK_BYP_18, `DDCPC_FRAME_CLOCK_BYP_16,
                                       `DDCPC_FRAME_CLOCK_BYP_14, `DDCPC_FRAME_CLOCK_BYP_18};
  logic [7:0]               pv [6] = '{8'h06, 8'h0E, 8'h16, 8'h3E, 8'h1E, 8'h0E};
  logic [7:0]               dv [6] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00};
  int                       mv [6] = '{0, 1, 2, 3, 1, 0};

  always #5 clk = ~clk;

  ddcpc_path_ctrl ddcpc_path_ctrl_inst (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sample_a(sample_a), .sample_b(sample_b),
    .bypass_resolution(bypass_resolution), .nco_phase(nco_phase),
    .filter_a_in(filter_a_in), .filter_b_in(filter_b_in), .filter_enable(filter_enable),
    .decim_ratio(decim_ratio), .decim_strobe(decim_strobe), .real_mode(real_mode),
    .complex_mix_enable(complex_mix_enable), .mixer_phase(mixer_phase),
    .path_a_out(path_a_out), .path_b_out(path_b_out), .path_valid(path_valid),
    .scrambler_enable(scrambler_enable), .frame_clock_pattern(frame_clock_pattern)
  );
  ddcpc_rx ddcpc_rx_inst (.clk(clk), .rst(rst), .valid(path_valid), .words(words));

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one single transfer; for reads d is the expected data
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= wr;
    htrans <= `DDCPC_HTRANS_NONSEQ;
    if (!wr) rq.push_back(d);
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    rdf <= !wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdf <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // random samples with the routed result noted per mode
  task automatic feed(input int n);
    ddcpc_pkg::ddcpc_sample_t a, b;
    logic signed [18:0]       s;
    repeat (n) begin
      @(posedge clk);
      a = 18'($random(seed));
      b = 18'($random(seed));
      s = a + b;
      sample_a <= a;
      sample_b <= b;
      dwatch <= 1'b1;
      case (mode)
        1: dq.push_back({1'b0, a, a});
        2: dq.push_back({1'b0, b, b});
        3: dq.push_back({1'b0, s[18:1], s[18:1]});
        4: dq.push_back({1'b1, a, b});
        default: dq.push_back({1'b0, a, b});
      endcase
    end
    @(posedge clk);
    dwatch <= 1'b0;
  endtask

  always @(posedge clk) begin
    logic [36:0] e;
    w1 <= dwatch;
    if (rdf) check("hrdata", rq.pop_front(), hrdata);
    if (w1 && dq.size() > 0) begin
      e = dq.pop_front();
      check("out_a", {14'h0, e[35:18]}, {14'h0, e[36] ? path_a_out : filter_a_in});
      check("out_b", {14'h0, e[17:0]}, {14'h0, e[36] ? path_b_out : filter_b_in});
    end
  end

  initial begin
    #200000;
    bad_count++;
    final_report;
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    settle(2);
    check("valid", 32'h1, {31'h0, path_valid});
    bus(0, 32'h90, 32'h0);
    bus(0, 32'h94, 32'h0);
    bus(0, 32'h84, 32'hFC);
    bus(0, 32'h88, 32'h0F);
    mode = 4;
    for (i = 0; i < 4; i++) begin
      bypass_resolution <= 2'(i);
      settle(2);
      check("frame_clock_auto", {12'h0, fp[i]}, {12'h0, frame_clock_pattern});
      feed(4);
    end
    bus(1, 32'h90, 32'hFF);
    bus(0, 32'h90, 32'h3E);
    bus(1, 32'h94, 32'hFF);
    bus(0, 32'h94, 32'hF9);
    bus(1, 32'h3FC, 32'h5A);
    bus(0, 32'h3FC, 32'h0);
    bus(0, 32'h91, 32'h0);
    for (i = 0; i < 6; i++) begin
      bus(1, 32'h94, {24'h0, dv[i]});
      bus(1, 32'h90, {24'h0, pv[i]});
      mode = mv[i];
      settle(2);
      feed(6);
    end
    check("cmix", 32'h1, {31'h0, complex_mix_enable});
    for (r = 0; r < 7; r++) begin
      bus(1, 32'h94, {25'h0, 3'(r), 4'h0});
      settle(2);
      check("ratio", (r > 5) ? 0 : r, {29'h0, decim_ratio});
      for (i = 0; i < 100 && path_valid !== 1'b1; i++) settle(1);
      w0 = words;
      settle(32);
      check("words", (r > 5) ? 32 : 32 >> r, {16'h0, words - w0});
    end
    bus(1, 32'h90, 32'h04);
    settle(2);
    check("filt_en", 32'h0, {31'h0, filter_enable});
    bus(1, 32'h90, 32'h06);
    for (i = 0; i < 2; i++) begin
      bus(1, 32'h94, 32'h08 | i);
      nco_phase <= $random(seed);
      settle(2);
      check("phase", i ? -nco_phase : nco_phase, mixer_phase);
      check("real", 32'h1, {31'h0, real_mode});
    end
    nco_phase <= 32'h0;
    settle(2);
    check("phase_zero", 32'h0, mixer_phase);
    bus(1, 32'h80, 32'h00);
    bus(1, 32'h84, 32'hE0);
    bus(1, 32'h88, 32'h4F);
    settle(2);
    check("frame_clock_prog", 32'hFE000, {12'h0, frame_clock_pattern});
    check("scr", 32'h1, {31'h0, scrambler_enable});
    bus(1, 32'h90, 32'h00);
    settle(2);
    check("scr_off", 32'h0, {31'h0, scrambler_enable});
    rst <= 1'b1;
    settle(2);
    rst <= 1'b0;
    settle(1);
    bus(0, 32'h88, 32'h0F);
    settle(2);
    final_report;
  end
endmodule
